// ---- hdl/tsi_top.sv ----
// Test start trigger and safety interlock controller with APB registers.
// Assumes raw pins are asynchronous; start input and loop return are active low
// in their meaning (start on low, error on low).
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R1: Software must set the external start enable before the start input has any effect.
// R2: With external start enabled an armed test waits and begins only once the input goes low.
// R3: While waiting for the external start a readable waiting status is shown.
// R4: After an external start every later change on the start input is ignored for that test.
// R5: The start reaction has a lag of at least 50 ms after the input goes low.
// R6: The outside party must keep the safety loop closed for the system to run.
// R7: An open loop stops a running test, refuses new starts and disables all outputs.
// R8: A low level on the loop return is an interlock error.
// R9: An interlock error lights the red error indicator.
// R10: Hardware reacts to the loop error at once; software is told well within 100 ms.
// R11: The loop return level is readable by the processor.
// R12: The active-low running indicator is low while a test runs and high otherwise.
// R13: Both inputs pass a two-flop synchroniser and a short debounce before use.
module tsi_top
  import tsi_pkg::*;
#(
  parameter longint unsigned LAG_CYCLES = START_LAG_CYC
)
(
  input wire logic pclk, // Clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic external_start_input, // Raw start pin, low starts
  input wire logic safety_loop_return, // Raw loop return, low is error
  output logic test_running_indicator_n, // Low while a test runs
  output logic outputs_enable, // Enables all output connections
  output logic error_led, // Red error indicator
  output logic irq // Level interrupt
);
  tsi_apb_req_s req;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic ext_en;
  logic start_lvl;
  logic loop_lvl;
  logic loop_err;
  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] ev;
  tsi_state_e state_reg;
  logic [31:0] lag_reg;
  logic arm_pulse;
  logic stop_pulse;
  logic run;
  logic [31:0] rdata_next;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  tsi_apb_regs u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .req(req),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wdata(wdata),
    .pslverr()
  );

  // Start pin idles high (no start)
  tsi_sync_deb #(.RST_VAL(1'b1)) u_start ( // [R13]
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_start_input),
    .level_out(start_lvl)
  );

  // Loop resets as open so nothing runs before it is seen closed
  tsi_sync_deb #(.RST_VAL(1'b0)) u_loop ( // [R13]
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(safety_loop_return),
    .level_out(loop_lvl)
  );

  // Low on the return means the loop is broken
  assign loop_err = !loop_lvl; // [R8] [R6]

  // Arm and stop are self-clearing command bits
  assign arm_pulse = wr_stb && (addr == OFS_CTRL) && wdata[CTRL_ARM_BIT];
  assign stop_pulse = wr_stb && (addr == OFS_CTRL) && wdata[CTRL_STOP_BIT];
  assign run = (state_reg == ST_RUN);
  // Enable written together with arm counts, so one write of both still waits
  assign ext_en = (wr_stb && addr == OFS_CTRL) ? wdata[CTRL_EXT_EN_BIT] :
    ctrl_reg[CTRL_EXT_EN_BIT]; // [R1] [R2]

  // Control register keeps only the enable bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RST;
    else if (wr_stb && addr == OFS_CTRL)
      ctrl_reg <= {31'h0000_0000, wdata[CTRL_EXT_EN_BIT]};
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_reg <= IRQ_MASK_RST;
    else if (wr_stb && addr == OFS_IRQ_MASK)
      irq_mask_reg <= wdata[IRQ_W-1:0];
  end

  // Test sequencer; loop error takes priority over everything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      lag_reg <= 32'h0000_0000;
    end
    else if (loop_err)
    begin
      state_reg <= ST_IDLE; // [R7] [R10]
      lag_reg <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (arm_pulse && !stop_pulse)
          begin
            if (ext_en)
              state_reg <= ST_WAIT_EXT; // [R1] [R2]
            else
              state_reg <= ST_RUN;
          end
        end
        ST_WAIT_EXT:
        begin
          if (stop_pulse)
            state_reg <= ST_IDLE;
          else if (!start_lvl)
          begin
            // Processor-handled start: the lag is a floor, not a ceiling
            state_reg <= ST_LAG; // [R2] [R5]
            lag_reg <= 32'h0000_0000;
          end
        end
        ST_LAG:
        begin
          // Start pin no longer looked at once the start is taken
          if (stop_pulse)
            state_reg <= ST_IDLE;
          else if (64'(lag_reg) >= LAG_CYCLES - 64'd1)
            state_reg <= ST_RUN; // [R5] [R4]
          else
            lag_reg <= lag_reg + 32'h0000_0001;
        end
        ST_RUN:
        begin
          if (stop_pulse)
            state_reg <= ST_IDLE; // [R4]
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Events: start, end of run, loop broken
  assign ev[IRQ_STARTED_BIT] = (state_reg != ST_RUN) && !loop_err &&
    ((state_reg == ST_IDLE && arm_pulse && !stop_pulse && !ext_en) ||
     (state_reg == ST_LAG && !stop_pulse && 64'(lag_reg) >= LAG_CYCLES - 64'd1));
  assign ev[IRQ_ENDED_BIT] = run && (loop_err || stop_pulse);
  assign ev[IRQ_LOOP_ERR_BIT] = loop_err; // [R10]

  // Sticky status; a read clears only the bits it reported (prdata, taken at setup),
  // so an event landing between setup and access is not lost; a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_reg <= '0;
    else if (rd_stb && addr == OFS_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~prdata[IRQ_W-1:0]) | ev; // [R10]
    else
      irq_stat_reg <= irq_stat_reg | ev;
  end

  // Read mux
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (addr)
      OFS_CTRL: rdata_next = ctrl_reg;
      OFS_STATUS:
      begin
        rdata_next[ST_WAIT_BIT] = (state_reg == ST_WAIT_EXT) || (state_reg == ST_LAG); // [R3]
        rdata_next[ST_RUN_BIT] = run;
        rdata_next[ST_LOOP_OK_BIT] = loop_lvl; // [R11]
        rdata_next[ST_ERR_LED_BIT] = loop_err;
        rdata_next[ST_START_RAW_BIT] = start_lvl;
      end
      OFS_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // APB answer registered in the setup cycle so it is ready at the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == OFS_CTRL || paddr == OFS_STATUS ||
        paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_MASK);
    end
  end

  // Pin outputs; disabling outputs follows the loop without waiting on software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_running_indicator_n <= 1'b1;
      outputs_enable <= 1'b0;
      error_led <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      test_running_indicator_n <= !(run && !loop_err); // [R12]
      outputs_enable <= !loop_err; // [R7]
      error_led <= loop_err; // [R9]
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule
`default_nettype wire

// ---- shared/tsi_pkg.sv ----
// Package for the test start trigger and safety interlock block.
// Assumes a 250 MHz pclk and an APB register bus with 32-bit data.
package tsi_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 250_000_000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  // Control register fields
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int CTRL_ARM_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  // Status register fields
  localparam int ST_WAIT_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_LOOP_OK_BIT = 2;
  localparam int ST_ERR_LED_BIT = 3;
  localparam int ST_START_RAW_BIT = 4;
  // Interrupt status fields
  localparam int IRQ_STARTED_BIT = 0;
  localparam int IRQ_ENDED_BIT = 1;
  localparam int IRQ_LOOP_ERR_BIT = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // Timing: processor reaction lag to an external start is at least 50 ms
  localparam int unsigned START_LAG_MS = 50;
  localparam longint unsigned START_LAG_CYC = (longint'(START_LAG_MS) * CLK_HZ + 999) / 1000;
  // Software notice of loop error within 100 ms (ours is the debounce plus a few cycles)
  localparam int unsigned NOTIFY_MAX_MS = 100;
  // Debounce: 1 us, a least time, rounded up
  localparam int unsigned DEB_NS = 1000;
  localparam int unsigned DEB_CYC = (DEB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Test sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EXT, ST_LAG, ST_RUN} tsi_state_e;
  // APB request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tsi_apb_req_s;
endpackage

// ---- hdl/tsi_sync_deb.sv ----
// Two-flop synchroniser plus a stable-count debounce for one pin.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module tsi_sync_deb
  import tsi_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic pin_in, // Raw pin
  output logic level_out // Debounced level
);
  logic s1_reg;
  logic s2_reg;
  logic [15:0] cnt_reg;

  // Two flops before any logic reads the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
    end
  end

  // Level must hold DEB_CYC cycles before it is accepted, filtering contact bounce
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 16'h0000;
      level_out <= RST_VAL;
    end
    else if (s2_reg == level_out)
      cnt_reg <= 16'h0000;
    else if (cnt_reg >= 16'(DEB_CYC - 1))
    begin
      cnt_reg <= 16'h0000;
      level_out <= s2_reg;
    end
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- hdl/tsi_apb_regs.sv ----
// APB slave front end: decodes a transfer into one-cycle read/write strobes.
// Assumes an APB master; pready goes high in every access phase so each access takes two cycles.
`timescale 1ns/1ns
`default_nettype none
module tsi_apb_regs
  import tsi_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire tsi_apb_req_s req, // Bundled APB request
  output logic wr_stb, // Write takes effect this cycle
  output logic rd_stb, // Read data taken this cycle
  output logic [7:0] addr, // Byte address, passed through unchanged
  output logic [31:0] wdata, // Write data
  output logic pslverr // Unmapped address answer
);
  logic mapped;

  // Only the four aligned words are mapped
  assign mapped = (req.addr == OFS_CTRL) || (req.addr == OFS_STATUS) ||
    (req.addr == OFS_IRQ_STAT) || (req.addr == OFS_IRQ_MASK);
  assign wr_stb = req.sel && req.enable && req.write && mapped;
  assign rd_stb = req.sel && req.enable && !req.write && mapped;
  assign addr = req.addr;
  assign wdata = req.wdata;
  assign pslverr = req.sel && req.enable && !mapped;
endmodule
`default_nettype wire

// ---- verif/tsi_top_properties.sv ----
// Port-level checks for the trigger and interlock block.
// Assumes the design's 250-cycle debounce and a two-flop input synchroniser.
`timescale 1ns/1ns
`default_nettype none
module tsi_chk
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic safety_loop_return, // Raw loop pin
  input wire logic test_running_indicator_n, // Running, low
  input wire logic outputs_enable, // Outputs on
  input wire logic error_led // Red indicator
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // APB phases as the slave sees them
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_ready_after_setup; s_setup |=> s_access; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data idle");
  property p_led_off_outputs; error_led |-> !outputs_enable; endproperty
  a_led_off_outputs: assert property (p_led_off_outputs) else $error("outputs on");
  property p_stop_on_err; error_led ##1 error_led |-> test_running_indicator_n; endproperty
  a_stop_on_err: assert property (p_stop_on_err) else $error("test runs in error");
  // Pipeline is 2 sync + 250 debounce + 1 output flop, so 260 leaves a small margin
  property p_err_within;
    $fell(safety_loop_return) |-> ##[1:260] (error_led || safety_loop_return);
  endproperty
  a_err_within: assert property (p_err_within) else $error("error late");
  // Writes may stop a test, so only quiet stretches are judged
  property p_run_holds;
    !test_running_indicator_n && !pwrite && !$past(pwrite) && !$past(pwrite, 2)
      |=> !test_running_indicator_n || error_led;
  endproperty
  a_run_holds: assert property (p_run_holds) else $error("test ended");
  property p_enable_cause; $rose(outputs_enable) |-> $past(safety_loop_return, 5); endproperty
  a_enable_cause: assert property (p_enable_cause) else $error("enable w/o loop");
endmodule
bind tsi_top tsi_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .safety_loop_return(safety_loop_return),
  .test_running_indicator_n(test_running_indicator_n),
  .outputs_enable(outputs_enable), .error_led(error_led));
`default_nettype wire

// ---- verif/tsi_partner.sv ----
// Model of the user's trigger source and the interlock wiring.
// Assumes the bench sets press and loop_closed after clock edges.
`timescale 1ns/1ns
`default_nettype none
module tsi_partner
(
  input wire logic press, // Start button held
  input wire logic loop_closed, // Link fitted
  output logic external_start_input, // Start pin, pulled up when idle
  output logic safety_loop_return // Loop pin, pulled down when open
);
  // Idle start pin rests high through its pull-up
  assign external_start_input = !press;
  // A fitted link holds the return high; an open one falls to the pull-down
  assign safety_loop_return = loop_closed;
endmodule
`default_nettype wire

// ---- verif/tb_tsi_top.sv ----
// Self-checking bench for the trigger and interlock block over APB.
// Assumes the partner model for the pins and a shortened start lag.
`timescale 1ns/1ns
`default_nettype none
module tb_tsi_top;
  import tsi_pkg::*;
  localparam int LAG = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, press = 0, loop_ok = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, ext_in, loop_in, run_n, out_en, led, irq;
  int err_total = 0, check_count = 0, n;
  always #2 pclk = ~pclk;
  tsi_top #(.LAG_CYCLES(LAG)) u_tsi_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_start_input(ext_in),
    .safety_loop_return(loop_in), .test_running_indicator_n(run_n),
    .outputs_enable(out_en), .error_led(led), .irq(irq));
  tsi_partner u_tsi_partner (.press(press), .loop_closed(loop_ok),
    .external_start_input(ext_in), .safety_loop_return(loop_in));
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    chk("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1)
      final_report;
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask
  // Bounded wait for a level; running out ends the run
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("wait level", {31'h0, v}, {31'h0, s});
    if (s !== v)
      final_report;
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (300) @(posedge pclk);
    chk("outputs_enable", 32'h1, {31'h0, out_en});
    rd(OFS_STATUS, 32'h14, "status idle");
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h7);
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (400) @(posedge pclk);
    rd(OFS_STATUS, 32'h15, "status waiting");
    chk("held", 32'h1, {31'h0, run_n});
    press <= 1'b1;
    wait_lvl(run_n, 1'b0, 400);
    chk("start lag", 32'h1, {31'h0, n >= LAG + 250 && n <= LAG + 270});
    press <= 1'b0;
    repeat (400) @(posedge pclk);
    chk("still running", 32'h0, {31'h0, run_n});
    chk("irq start", 32'h1, {31'h0, irq});
    rd(OFS_IRQ_STAT, 32'h1, "stat started");
    rd(OFS_STATUS, 32'h16, "status running");
    chk("irq cleared", 32'h0, {31'h0, irq});
    loop_ok <= 1'b0;
    wait_lvl(led, 1'b1, 260);
    chk("outputs off", 32'h0, {31'h0, out_en});
    chk("stopped", 32'h1, {31'h0, run_n});
    rd(OFS_IRQ_STAT, 32'h6, "stat loop");
    rd(OFS_STATUS, 32'h18, "status open");
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (10) @(posedge pclk);
    chk("arm refused", 32'h1, {31'h0, run_n});
    loop_ok <= 1'b1;
    repeat (300) @(posedge pclk);
    chk("no late start", 32'h1, {31'h0, run_n});
    rd(OFS_IRQ_STAT, 32'h4, "stat loop held");
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h2);
    wait_lvl(run_n, 1'b0, 30);
    apb(1'b1, OFS_CTRL, 32'h4);
    wait_lvl(run_n, 1'b1, 5);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rd(OFS_IRQ_STAT, 32'h3, "stat run end");
    rd(8'h10, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, e});
    final_report;
  end
endmodule
`default_nettype wire
